// *** design/pulse_pattern_unit.sv ***
// pulse pattern output unit: next-data to output latch on timer events
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] In non-overlap mode compare match A copies every enabled next bit to the latch.
// [R2] In non-overlap mode compare match B copies only next bits that are 0.
// [R3] The controller leaves next data alone between match B and the next match A.
// [R4] The controller loads the following next data after match A and before match B.
// [R5] A group whose invert select is 0 drives the complement of its latch bits.
// [R6] When register A of the chosen channel captures, its capture event is the trigger.
// [R7] After reset the unit stays stopped and ignores writes until module stop clears.
// [R8] A pin whose other peripheral is enabled carries that peripheral's output.
// [R9] Latch transfers happen even on pins given to another function.
// [R10] The controller switches pin functions only while no trigger can occur.
// [R11] In normal mode match A moves upper next bits to the upper latch and pins.
// [R12] There are sixteen pulse output bits, each shared with other peripherals.
// [R13] Only bits with next enable 1 are updated; the latch preset gives the first level.
// [R14] Each group picks timer channel 0 to 3 with its two-bit select code.
// [R15] With non-overlap select 0 a group updates only at compare match A.
// [R16] The latch updates in the trigger cycle; a next-data change then waits a trigger.
module pulse_pattern_unit
   import pulse_pattern_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // control bits
   input  wire logic        module_stop_i,
   input  wire logic [15:0] next_bit_enables_i,
   input  wire logic [7:0]  group_trigger_select_i,
   input  wire logic [7:0]  group_output_mode_i,
   input  wire logic        latch_preset_write_i,
   input  wire logic [15:0] latch_preset_data_i,
   // next data stream
   input  wire logic        next_valid_i,
   output logic             next_ready_o,
   input  wire logic [15:0] next_data_i,
   // timer pulse unit events, one bit per channel
   input  wire logic [3:0]  match_a_i,
   input  wire logic [3:0]  match_b_i,
   input  wire logic [3:0]  capture_a_i,
   input  wire logic [3:0]  reg_a_is_capture_i,
   // other peripherals on shared pins
   input  wire logic [15:0] other_enable_i,
   input  wire logic [15:0] other_data_i,
   // pins and status
   output logic [15:0]      pulse_pins_o,
   output logic [15:0]      pulse_oe_n_o,
   output logic [15:0]      output_latch_bits_o,
   output logic [15:0]      next_output_bits_o,
   output logic             next_loaded_o,
   output logic             stopped_o
);
   function automatic logic [1:0] group_channel(input logic [7:0] sel, input int g);
      group_channel = sel[2*g +: 2];
   endfunction

   function automatic logic pick_channel(input logic [3:0] ev, input logic [1:0] ch);
      pick_channel = ev[ch];
   endfunction

   logic             stop_q, stop_d;
   logic [15:0]      latch_q, latch_d;
   logic [15:0]      next_q, next_d;
   logic [15:0]      pins_q, pins_d;
   logic [15:0]      oe_n_q, oe_n_d;
   logic [3:0]       used_q, used_d;
   nd_state_e        nd_state_q, nd_state_d;
   logic [3:0]       trig_a, trig_b, nov, inv, active;
   logic             fifo_valid, fifo_take;
   logic [15:0]      fifo_data;

   // trigger selection per group
   always_comb begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
         // [R14] channel select decode
         // [R6] capture replaces match A
         trig_a[g] = pick_channel(reg_a_is_capture_i, group_channel(group_trigger_select_i, g))
                   ? pick_channel(capture_a_i, group_channel(group_trigger_select_i, g))
                   : pick_channel(match_a_i, group_channel(group_trigger_select_i, g));
         trig_b[g] = pick_channel(match_b_i, group_channel(group_trigger_select_i, g));
         nov[g]    = group_output_mode_i[NOV_POS + g];
         inv[g]    = group_output_mode_i[INV_POS + g];
         active[g] = |next_bit_enables_i[g*GROUP_BITS +: GROUP_BITS];
      end
   end

   // output latch, stop control and pins
   always_comb begin
      // [R7] held in stop after reset
      stop_d  = module_stop_i;
      latch_d = latch_q;
      if (!stop_q) begin
         // [R13] preset gives the first level
         if (latch_preset_write_i) begin
            latch_d = latch_preset_data_i;
         end
         for (int b = 0; b < NUM_BITS; b++) begin
            // [R9] copy ignores pin ownership; [R13] enabled bits only
            if (next_bit_enables_i[b]) begin
               // [R1] [R11] [R16] match A copies current next data
               if (trig_a[b / GROUP_BITS]) begin
                  latch_d[b] = next_q[b];
               // [R2] [R15] match B copies zeros only in non-overlap mode
               end else if (nov[b / GROUP_BITS] && trig_b[b / GROUP_BITS]) begin
                  latch_d[b] = latch_q[b] & next_q[b];
               end
            end
         end
      end
      for (int b = 0; b < NUM_BITS; b++) begin
         // [R8] other function owns the pin
         if (other_enable_i[b]) begin
            pins_d[b] = other_data_i[b];
            oe_n_d[b] = 1'b0;
         // [R7] stopped unit keeps its pins as they were
         end else if (stop_q) begin
            pins_d[b] = pins_q[b];
            oe_n_d[b] = oe_n_q[b];
         end else begin
            // [R5] complement when invert select is 0
            pins_d[b] = next_bit_enables_i[b] && (inv[b / GROUP_BITS] ? latch_d[b] : ~latch_d[b]);
            oe_n_d[b] = !next_bit_enables_i[b];
         end
      end
   end

   // next-data holding register; a word stays until every active group saw match A,
   // so a held word is replaced only after match A; a word that finds none held lands at once
   always_comb begin
      next_d     = next_q;
      used_d     = used_q;
      nd_state_d = nd_state_q;
      fifo_take  = 1'b0;
      if (!stop_q) begin
         case (nd_state_q)
            ND_EMPTY: begin
               if (fifo_valid) begin
                  fifo_take  = 1'b1;
                  next_d     = fifo_data;
                  used_d     = USED_RESET;
                  nd_state_d = ND_HELD;
               end
            end
            ND_HELD: begin
               // [R4] reload only after match A
               used_d = used_q | trig_a;
               if ((&(used_d | ~active)) && (|active)) begin
                  nd_state_d = ND_EMPTY;
               end
            end
            default: begin
               nd_state_d = ND_EMPTY;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stop_q     <= STOP_RESET;
         latch_q    <= LATCH_RESET;
         next_q     <= NEXT_RESET;
         pins_q     <= PINS_RESET;
         oe_n_q     <= OE_N_RESET;
         used_q     <= USED_RESET;
         nd_state_q <= ND_EMPTY;
      end else begin
         stop_q     <= stop_d;
         latch_q    <= latch_d;
         next_q     <= next_d;
         pins_q     <= pins_d;
         oe_n_q     <= oe_n_d;
         used_q     <= used_d;
         nd_state_q <= nd_state_d;
      end
   end

   // fifo refuses words while stopped
   pulse_word_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (next_valid_i),
      .in_ready_o  (next_ready_o),
      .in_data_i   (next_data_i),
      .hold_i      (stop_d),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_take),
      .out_data_o  (fifo_data)
   );

   // [R12] sixteen pins from flops
   assign pulse_pins_o        = pins_q;
   assign pulse_oe_n_o        = oe_n_q;
   assign output_latch_bits_o = latch_q;
   assign next_output_bits_o  = next_q;
   // held is the upper one-hot bit, read straight from its flop
   assign next_loaded_o       = nd_state_q[1];
   assign stopped_o           = stop_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_stopped;
      stop_q && !latch_preset_write_i;
   endsequence

   // preset with no trigger that would override it
   sequence s_preset_only;
      !stop_q && latch_preset_write_i && trig_a == 4'h0 && (trig_b & nov) == 4'h0;
   endsequence

   a_stop_holds_latch: // [R7]
   assert property (s_stopped |=> $stable(output_latch_bits_o))
      else $error("latch changed while stopped");

   a_stop_holds_next: // [R7]
   assert property (stop_q ##1 stop_q |-> $stable(next_output_bits_o))
      else $error("next data loaded while stopped");

   a_other_owns_pin: // [R8]
   assert property (other_enable_i != 16'h0000 |=>
                    ((pulse_pins_o ^ $past(other_data_i)) & $past(other_enable_i)) == 16'h0000
                    && (pulse_oe_n_o & $past(other_enable_i)) == 16'h0000)
      else $error("shared pin not given to other peripheral");

   a_disabled_bit_held: // [R13]
   assert property (!stop_q && !latch_preset_write_i && next_bit_enables_i != 16'hffff
                    |=> ((output_latch_bits_o ^ $past(output_latch_bits_o))
                         & ~$past(next_bit_enables_i)) == 16'h0000
                    && (~pulse_oe_n_o & ~$past(next_bit_enables_i | other_enable_i)) == 16'h0000)
      else $error("disabled bit changed or driven");

   a_next_waits_match: // [R4]
   assert property (next_loaded_o && !stop_q && trig_a == 4'h0 && trig_b == 4'h0
                    |=> $stable(next_output_bits_o))
      else $error("next data replaced without match A");

   a_stop_refuses_next: // [R7]
   assert property (stop_q |-> !next_ready_o)
      else $error("next word accepted while stopped");

   a_stop_holds_pins: // [R7]
   assert property (stop_q && other_enable_i == 16'h0000
                    |=> $stable(pulse_pins_o) && $stable(pulse_oe_n_o))
      else $error("pins moved while stopped");

   a_preset_loads: // [R13]
   assert property (s_preset_only |=> output_latch_bits_o == $past(latch_preset_data_i))
      else $error("preset not loaded into latch");

   a_pins_driven: // [R13]
   assert property (!stop_q
                    |=> (pulse_oe_n_o & $past(next_bit_enables_i | other_enable_i)) == 16'h0000)
      else $error("enabled pin left undriven");

   a_word_loads: // [R4]
   assert property (!stop_q && !next_loaded_o && fifo_valid
                    |=> next_loaded_o && next_output_bits_o == $past(fifo_data))
      else $error("queued word not moved to next data");

   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_chk
      localparam int LO = g * GROUP_BITS;

      sequence s_match_a;
         !stop_q && trig_a[g];
      endsequence

      sequence s_match_b_only;
         !stop_q && trig_b[g] && !trig_a[g] && !latch_preset_write_i;
      endsequence

      a_match_a_copy: // [R1]
      assert property (s_match_a |=> ((output_latch_bits_o[LO +: 4] ^ $past(next_output_bits_o[LO +: 4]))
                                      & $past(next_bit_enables_i[LO +: 4])) == 4'h0)
         else $error("match A did not copy next data");

      a_match_b_zeros: // [R2]
      assert property (s_match_b_only and nov[g] |=> output_latch_bits_o[LO +: 4] ==
                       ($past(output_latch_bits_o[LO +: 4]) &
                        ($past(next_output_bits_o[LO +: 4]) | ~$past(next_bit_enables_i[LO +: 4]))))
         else $error("match B transfer wrong");

      a_normal_ignores_b: // [R15]
      assert property (s_match_b_only and !nov[g] |=> $stable(output_latch_bits_o[LO +: 4]))
         else $error("normal mode updated on match B");

      a_invert_pins: // [R5]
      assert property (##1 (!$past(inv[g]) && $past(other_enable_i[LO +: 4]) == 4'h0
                            && $past(next_bit_enables_i[LO +: 4]) == 4'hf && !$past(stop_q))
                       |-> pulse_pins_o[LO +: 4] == ~output_latch_bits_o[LO +: 4])
         else $error("inverted pins wrong");

      a_capture_trigger: // [R6]
      assert property (!stop_q && pick_channel(reg_a_is_capture_i, group_channel(group_trigger_select_i, g))
                       && pick_channel(match_a_i, group_channel(group_trigger_select_i, g))
                       && !pick_channel(capture_a_i, group_channel(group_trigger_select_i, g))
                       && !trig_b[g] && !latch_preset_write_i
                       |=> $stable(output_latch_bits_o[LO +: 4]))
         else $error("compare match used while register A captures");
   end
endmodule // pulse_pattern_unit
`default_nettype wire

// *** design/pulse_word_fifo.sv ***
// word fifo feeding next-output data, registered read stage
`timescale 1ns/1ps
`default_nettype none
module pulse_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             hold_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q, wr_ptr_d;
   logic [PW-1:0]    rd_ptr_q, rd_ptr_d;
   logic [CW-1:0]    count_q, count_d;
   logic             ready_q, ready_d;
   logic             valid_q, valid_d;
   logic [WIDTH-1:0] data_q, data_d;
   logic             push, pop;

   always_comb begin
      // read stage refills when empty or being taken; write side refused while held
      push     = in_valid_i && ready_q;
      pop      = (count_q != '0) && (!valid_q || out_ready_i);
      wr_ptr_d = push ? PW'(wr_ptr_q + 1'b1) : wr_ptr_q;
      rd_ptr_d = pop ? PW'(rd_ptr_q + 1'b1) : rd_ptr_q;
      count_d  = CW'(count_q + CW'(push) - CW'(pop));
      ready_d  = (count_d != FULL_COUNT) && !hold_i;
      valid_d  = pop ? 1'b1 : (out_ready_i ? 1'b0 : valid_q);
      data_d   = pop ? mem_q[rd_ptr_q] : data_q;
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
         ready_q  <= 1'b0;
         valid_q  <= 1'b0;
         data_q   <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
         ready_q  <= ready_d;
         valid_q  <= valid_d;
         data_q   <= data_d;
      end
   end

   assign in_ready_o  = ready_q;
   assign out_valid_o = valid_q;
   assign out_data_o  = data_q;
endmodule // pulse_word_fifo
`default_nettype wire

// *** shared/pulse_pattern_pkg.sv ***
// constants and types shared by the pulse pattern unit
package pulse_pattern_pkg;
   localparam int          NUM_BITS       = 16;
   localparam int          NUM_GROUPS     = 4;
   localparam int          GROUP_BITS     = 4;
   localparam int          NUM_CHANNELS   = 4;
   localparam int          FIFO_WIDTH     = 16;
   localparam int          FIFO_DEPTH     = 32;
   // field positions inside the output mode byte
   localparam int          NOV_POS        = 0;
   localparam int          INV_POS        = 4;
   // values after reset
   localparam logic [15:0] LATCH_RESET    = 16'h0000;
   localparam logic [15:0] NEXT_RESET     = 16'h0000;
   localparam logic [15:0] PINS_RESET     = 16'h0000;
   localparam logic [15:0] OE_N_RESET     = 16'hffff;
   localparam logic [3:0]  USED_RESET     = 4'h0;
   localparam logic        STOP_RESET     = 1'b1;
   // one-hot states of the next-data holding register
   typedef enum logic [1:0] {
      ND_EMPTY = 2'b01,
      ND_HELD  = 2'b10
   } nd_state_e;
endpackage : pulse_pattern_pkg

// *** verification/tb_top.sv ***
// self-checking bench for the pulse pattern unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pulse_pattern_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        module_stop_i = 1'b1;
   logic [15:0] next_bit_enables_i = 16'hffff;
   logic [7:0]  group_trigger_select_i = 8'he4;
   logic [7:0]  group_output_mode_i = 8'hf0;
   logic        latch_preset_write_i = 1'b0;
   logic [15:0] latch_preset_data_i = 16'h0000;
   logic        next_valid_i = 1'b0;
   logic [15:0] next_data_i = 16'h0000;
   logic [15:0] other_enable_i = 16'h0000;
   logic [15:0] other_data_i = 16'h0000;
   logic [3:0]  match_a, match_b, capture_a, reg_a_cap;
   logic        next_ready_o, next_loaded_o, stopped_o;
   logic [15:0] pulse_pins_o, pulse_oe_n_o, output_latch_bits_o, next_output_bits_o;
   int          num_errors = 0;
   int          checked = 0;

   always #50 clk_i = ~clk_i;

   timer_event_model events_u (.clk_i(clk_i), .match_a_o(match_a), .match_b_o(match_b),
      .capture_a_o(capture_a), .reg_a_is_capture_o(reg_a_cap));

   pulse_pattern_unit DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .module_stop_i(module_stop_i),
      .next_bit_enables_i(next_bit_enables_i), .group_trigger_select_i(group_trigger_select_i),
      .group_output_mode_i(group_output_mode_i), .latch_preset_write_i(latch_preset_write_i),
      .latch_preset_data_i(latch_preset_data_i), .next_valid_i(next_valid_i),
      .next_ready_o(next_ready_o), .next_data_i(next_data_i), .match_a_i(match_a),
      .match_b_i(match_b), .capture_a_i(capture_a), .reg_a_is_capture_i(reg_a_cap),
      .other_enable_i(other_enable_i), .other_data_i(other_data_i),
      .pulse_pins_o(pulse_pins_o), .pulse_oe_n_o(pulse_oe_n_o),
      .output_latch_bits_o(output_latch_bits_o), .next_output_bits_o(next_output_bits_o),
      .next_loaded_o(next_loaded_o), .stopped_o(stopped_o));

   task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp, input string msg);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s got %b", $time, msg, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic expect_out(input logic [15:0] l, input logic [15:0] p, input logic [15:0] e);
      check16(output_latch_bits_o, l, "latch");
      check16(pulse_pins_o, p, "pins");
      check16(pulse_oe_n_o, e, "oe_n");
   endtask
   // holds valid and data until ready is seen at an edge
   task automatic push(input logic [15:0] w);
      int n;
      next_valid_i = 1'b1;
      next_data_i  = w;
      for (n = 0; n < 50 && next_ready_o !== 1'b1; n++) tick(1);
      tick(1);
      next_valid_i = 1'b0;
      for (n = 0; n < 20 && !(next_loaded_o === 1'b1 && next_output_bits_o === w); n++) tick(1);
      check16(next_output_bits_o, w, "next word");
      check1(next_loaded_o, 1'b1, "loaded");
   endtask

   task automatic t_stop();
      expect_out(LATCH_RESET, PINS_RESET, OE_N_RESET);
      check1(stopped_o, 1'b1, "stopped");
      check1(next_ready_o, 1'b0, "ready while stopped");
      latch_preset_data_i  = 16'h5555;
      latch_preset_write_i = 1'b1;
      tick(1);
      latch_preset_write_i = 1'b0;
      expect_out(LATCH_RESET, PINS_RESET, OE_N_RESET);
      module_stop_i = 1'b0;
      tick(2);
      check1(stopped_o, 1'b0, "running");
      latch_preset_data_i  = 16'h00ff;
      latch_preset_write_i = 1'b1;
      tick(1);
      latch_preset_write_i = 1'b0;
      check16(output_latch_bits_o, 16'h00ff, "preset");
   endtask

   task automatic t_groups();
      logic [15:0] exp_l [4] = '{16'h00f4, 16'h0034, 16'h0234, 16'h1234};
      push(16'h1234);
      for (int g = 0; g < 4; g++) begin
         events_u.fire(0, 4'h1 << g, g);
         expect_out(exp_l[g], exp_l[g], 16'h0000);
      end
   endtask

   task automatic t_nonoverlap();
      group_trigger_select_i = 8'h00;
      push(16'h95a5);
      events_u.fire(1, 4'h1, 0);
      check16(output_latch_bits_o, 16'h1234, "b in normal");
      group_output_mode_i = 8'hff;
      events_u.fire(1, 4'h1, 2);
      expect_out(16'h1024, 16'h1024, 16'h0000);
      events_u.fire(0, 4'h1, 3);
      expect_out(16'h95a5, 16'h95a5, 16'h0000);
   endtask

   task automatic t_invert();
      group_output_mode_i = 8'hc0;
      push(16'h6559);
      events_u.fire(0, 4'h1, 0);
      expect_out(16'h6559, 16'h65a6, 16'h0000);
   endtask

   task automatic t_shared();
      group_output_mode_i = 8'hf0;
      // pin function moved while no event is due
      other_data_i   = 16'h00a0;
      other_enable_i = 16'h00f0;
      push(16'h3c5a);
      events_u.fire(0, 4'h1, 1);
      expect_out(16'h3c5a, 16'h3caa, 16'h0000);
      other_enable_i = 16'h0000;
   endtask

   task automatic t_capture();
      events_u.set_capture(4'h1);
      push(16'h5a5a);
      events_u.fire(0, 4'h1, 0);
      check16(output_latch_bits_o, 16'h3c5a, "match a ignored");
      events_u.fire(2, 4'h1, 1);
      check16(output_latch_bits_o, 16'h5a5a, "capture");
      events_u.set_capture(4'h0);
   endtask

   task automatic t_enables();
      next_bit_enables_i = 16'h00ff;
      push(16'hffff);
      events_u.fire(0, 4'h1, 0);
      expect_out(16'h5aff, 16'h00ff, 16'hff00);
      next_bit_enables_i = 16'hffff;
   endtask

   // fill with the timer stalled, then drain one word per match a
   task automatic t_fifo();
      int   taken;
      logic r;
      taken = 0;
      next_valid_i = 1'b1;
      for (int n = 0; n < 48; n++) begin
         next_data_i = 16'h0100 + 16'(taken);
         r = next_ready_o;
         tick(1);
         if (r === 1'b1) taken++;
      end
      next_valid_i = 1'b0;
      check1(next_ready_o, 1'b0, "full refuses");
      check1(taken >= FIFO_DEPTH, 1'b1, "depth");
      for (int n = 0; n < 60 && next_loaded_o === 1'b1; n++) begin
         events_u.fire(0, 4'h1, 0);
         tick(2);
      end
      check16(output_latch_bits_o, 16'h0100 + 16'(taken - 1), "last word");
      check1(next_loaded_o, 1'b0, "drained");
      check1(next_ready_o, 1'b1, "ready again");
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // the tests need about 270 cycles; allow a wide margin
   initial begin
      #(100 * 5000);
      num_errors++;
      $display("CHECK FAILED t=%0t watchdog", $time);
      final_report();
   end

   initial begin
      repeat (12) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      tick(1);
      t_stop();
      t_groups();
      t_nonoverlap();
      t_invert();
      t_shared();
      t_capture();
      t_enables();
      t_fifo();
      final_report();
   end
endmodule // tb_top
`default_nettype wire

// *** verification/timer_event_model.sv ***
// timer pulse unit model: one-cycle compare and capture events
`timescale 1ns/1ps
`default_nettype none
module timer_event_model (
   // clock
   input  wire logic  clk_i,
   // events, one bit per channel
   output logic [3:0] match_a_o,
   output logic [3:0] match_b_o,
   output logic [3:0] capture_a_o,
   output logic [3:0] reg_a_is_capture_o
);
   initial begin
      match_a_o          = 4'h0;
      match_b_o          = 4'h0;
      capture_a_o        = 4'h0;
      reg_a_is_capture_o = 4'h0;
   end
   // kind 0 match a, 1 match b, 2 capture a; gap makes the timer slow
   task automatic fire(input int kind, input logic [3:0] ch, input int gap);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      #1;
      case (kind)
         0: match_a_o = ch;
         1: match_b_o = ch;
         default: capture_a_o = ch;
      endcase
      @(posedge clk_i);
      #1;
      match_a_o   = 4'h0;
      match_b_o   = 4'h0;
      capture_a_o = 4'h0;
   endtask
   // register a set up as capture only while no event is due
   task automatic set_capture(input logic [3:0] ch);
      @(posedge clk_i);
      #1;
      reg_a_is_capture_o = ch;
   endtask
endmodule // timer_event_model
`default_nettype wire
